/* core/arp_pkg.sv */
// Constants, types and helpers shared by the result output port
package arp_pkg;

  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam int          ADDR_W       = 12;
  localparam logic [11:0] ADDR_CTRL    = 12'h000;
  localparam logic [11:0] ADDR_STATUS  = 12'h004;
  localparam logic [11:0] ADDR_RESULT  = 12'h008;

  localparam int          CTRL_W         = 5;
  localparam int          CTRL_PORT_SEL  = 0;
  localparam int          CTRL_CLK_SRC   = 1;
  localparam int          CTRL_INV_CLK   = 2;
  localparam int          CTRL_CODE_FMT  = 3;
  localparam int          CTRL_FRAME_POL = 4;
  localparam logic [4:0]  CTRL_RESET     = 5'h08;

  localparam int          STAT_BUSY  = 0;
  localparam int          STAT_HELD  = 1;
  localparam int          STAT_CHAIN = 2;

  // ****************************************************************
  // Result and pin layout
  // ****************************************************************
  localparam int          RES_W       = 16;
  localparam int          RES_MSB     = 15;
  localparam int          PAR_CHAIN   = 7;
  localparam int          PAR_DOUT    = 8;
  localparam int          PAR_SCLK    = 9;
  localparam logic [4:0]  BITS_READ   = 5'h10;
  localparam logic [4:0]  BITS_LAST   = 5'h0F;

  // ****************************************************************
  // Internal serial clock timing
  // ****************************************************************
  localparam int          MCLK_PERIOD_NS = 5;
  localparam int          SCLK_PHASE_NS  = 20;
  localparam int          PHASE_CYC      = (SCLK_PHASE_NS + MCLK_PERIOD_NS - 1) / MCLK_PERIOD_NS;
  localparam int          DIV_W          = 3;
  localparam logic [2:0]  DIV_LAST       = 3'(PHASE_CYC - 1);

  localparam logic [1:0]  PH_DATA = 2'h0;
  localparam logic [1:0]  PH_RISE = 2'h1;
  localparam logic [1:0]  PH_HOLD = 2'h2;
  localparam logic [1:0]  PH_FALL = 2'h3;

  typedef enum logic [1:0] {
    ST_IDLE      = 2'b00,
    ST_INT_SHIFT = 2'b01,
    ST_EXT_SHIFT = 2'b10
  } arp_state_t;

  // Format high keeps straight binary, low flips the MSB
  function automatic logic [15:0] arp_coded(input logic [15:0] raw, input logic fmt);
    arp_coded = {raw[RES_MSB] ^ ~fmt, raw[RES_MSB-1:0]};
  endfunction

endpackage

/* core/arp_sync.sv */
// Two-stage synchroniser for pin inputs
`timescale 1ns/1ps
`default_nettype none
module arp_sync #(
  parameter int WIDTH = 2
) (
  input  wire logic             mclk,
  input  wire logic             arst_n,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] stage1;

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      stage1   <= '0;
      sync_out <= '0;
    end else begin
      stage1   <= async_in;
      sync_out <= stage1;
    end
  end
endmodule
`default_nettype wire

/* core/arp_clkdiv.sv */
// Divider giving one-cycle phase ticks for the internal serial clock
`timescale 1ns/1ps
`default_nettype none
module arp_clkdiv
  import arp_pkg::*;
(
  input  wire logic mclk,
  input  wire logic arst_n,
  input  wire logic run,
  output logic      tick
);
  logic [DIV_W-1:0] count;

  // Restarts from zero each read so the first phase is full length
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      count <= '0;
    end else if (!run || count == DIV_LAST) begin
      count <= '0;
    end else begin
      count <= count + 3'h1;
    end
  end

  assign tick = run && (count == DIV_LAST);
endmodule
`default_nettype wire

/* core/arp_port.sv */
// Serial/parallel result output port with APB control
//
// Added by the designer: the register addresses and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module arp_port (
  input  wire logic                       mclk,
  input  wire logic                       arst_n,
  // APB slave
  input  wire logic                       psel,
  input  wire logic                       penable,
  input  wire logic                       pwrite,
  input  wire logic [arp_pkg::ADDR_W-1:0] paddr,
  input  wire logic [31:0]                pwdata,
  output logic      [31:0]                prdata,
  output logic                            pready,
  output logic                            pslverr,
  // Conversion core side
  input  wire logic [arp_pkg::RES_W-1:0]  conv_result,
  input  wire logic                       conv_done,
  input  wire logic                       conv_start,
  // Shared pins
  input  wire logic                       pin_d7_in,
  output logic                            pin_d7_out,
  output logic                            pin_d7_oe,
  output logic                            pin_d8_out,
  output logic                            pin_d8_oe,
  input  wire logic                       pin_d9_in,
  output logic                            pin_d9_out,
  output logic                            pin_d9_oe,
  output logic                            frame_marker
);
  import arp_pkg::*;

  // ****************************************************************
  // Declarations
  // ****************************************************************
  logic [CTRL_W-1:0] ctrl;
  logic [RES_W-1:0]  held;
  logic              held_valid;
  logic [RES_W-1:0]  shreg;
  logic [4:0]        bit_cnt;
  logic [1:0]        phase;
  logic              sclk_int;
  arp_state_t        state;
  logic              sclk_s;
  logic              chain_s;
  logic              sclk_d;
  logic              chain_bit;
  logic              tick;
  logic [RES_W-1:0]  held_c;
  logic              serial;
  logic              ext;
  logic              inv;
  logic              fmt;
  logic              pol;
  logic              ext_rise;
  logic              ext_fall;
  logic              ext_upd;
  logic              ext_smp;
  logic              int_start;
  logic              ext_load;
  logic              rd_busy;
  logic              apb_wr;
  logic              apb_setup;

  assign serial = ctrl[CTRL_PORT_SEL];
  assign ext    = ctrl[CTRL_CLK_SRC];
  assign inv    = ctrl[CTRL_INV_CLK];
  assign fmt    = ctrl[CTRL_CODE_FMT];
  assign pol    = ctrl[CTRL_FRAME_POL];
  assign held_c = arp_coded(held, fmt);

  // ****************************************************************
  // Pin inputs and external clock edges
  // ****************************************************************
  arp_sync #(.WIDTH(2)) u_sync (
    .mclk     (mclk),
    .arst_n   (arst_n),
    .async_in ({pin_d9_in, pin_d7_in}),
    .sync_out ({sclk_s, chain_s})
  );

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      sclk_d <= 1'b0;
    end else begin
      sclk_d <= sclk_s;
    end
  end

  assign ext_rise = sclk_s && !sclk_d;
  assign ext_fall = !sclk_s && sclk_d;
  assign ext_upd  = inv ? ext_fall : ext_rise;
  assign ext_smp  = inv ? ext_rise : ext_fall;

  // Chain level is caught on the edge opposite the update edge
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      chain_bit <= 1'b0;
    end else if (ext_smp) begin
      chain_bit <= chain_s;
    end
  end

  // ****************************************************************
  // Held result
  // ****************************************************************
  assign int_start = serial && !ext && (state == ST_IDLE)
                     && (chain_s ? conv_start : conv_done);
  assign ext_load  = serial && ext && conv_done;

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      held <= '0;
    end else if (conv_done) begin
      held <= conv_result;
    end
  end

  // A new result beats a read start taking the old one
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      held_valid <= 1'b0;
    end else if (conv_done) begin
      held_valid <= 1'b1;
    end else if (int_start) begin
      held_valid <= 1'b0;
    end
  end

  // ****************************************************************
  // Shift engine
  // ****************************************************************
  arp_clkdiv u_div (
    .mclk   (mclk),
    .arst_n (arst_n),
    .run    (state == ST_INT_SHIFT),
    .tick   (tick)
  );

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      state <= ST_IDLE;
    end else if (!serial) begin
      state <= ST_IDLE;
    end else begin
      case (state)
        ST_IDLE: begin
          if (ext_load) begin
            state <= ST_EXT_SHIFT;
          end else if (int_start) begin
            state <= ST_INT_SHIFT;
          end
        end
        ST_INT_SHIFT: begin
          if (ext) begin
            state <= ST_IDLE;
          end else if (tick && phase == PH_FALL && bit_cnt == BITS_LAST) begin
            state <= ST_IDLE;
          end
        end
        ST_EXT_SHIFT: begin
          if (!ext) begin
            state <= ST_IDLE;
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  // Fresh result goes straight to the shifter in read-after-convert mode
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      shreg <= '0;
    end else if (ext_load) begin
      shreg <= arp_coded(conv_result, fmt);
    end else if (int_start) begin
      shreg <= arp_coded(chain_s ? held : conv_result, fmt);
    end else if (state == ST_EXT_SHIFT && ext_upd) begin
      shreg <= {shreg[RES_MSB-1:0], chain_bit};
    end else if (state == ST_INT_SHIFT && tick && phase == PH_FALL) begin
      shreg <= {shreg[RES_MSB-1:0], 1'b0};
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      bit_cnt <= '0;
    end else if (ext_load || int_start) begin
      bit_cnt <= '0;
    end else if (state == ST_EXT_SHIFT && ext_upd && bit_cnt != BITS_READ) begin
      bit_cnt <= bit_cnt + 5'h01;
    end else if (state == ST_INT_SHIFT && tick && phase == PH_FALL) begin
      bit_cnt <= bit_cnt + 5'h01;
    end
  end

  // Four phases per bit: data moves only while the clock sits low
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      phase    <= PH_DATA;
      sclk_int <= 1'b0;
    end else if (state != ST_INT_SHIFT) begin
      phase    <= PH_DATA;
      sclk_int <= 1'b0;
    end else if (tick) begin
      phase <= phase + 2'h1;
      if (phase == PH_DATA) begin
        sclk_int <= 1'b1;
      end else if (phase == PH_HOLD) begin
        sclk_int <= 1'b0;
      end
    end
  end

  assign rd_busy = (state == ST_INT_SHIFT)
                   || (state == ST_EXT_SHIFT && bit_cnt != BITS_READ);

  // ****************************************************************
  // Pin drive
  // ****************************************************************
  always_comb begin
    pin_d7_out = held_c[PAR_CHAIN];
    pin_d7_oe  = !serial;
    pin_d8_out = serial ? shreg[RES_MSB] : held_c[PAR_DOUT];
    pin_d8_oe  = 1'b1;
    pin_d9_out = serial ? (sclk_int ^ inv) : held_c[PAR_SCLK];
    pin_d9_oe  = !(serial && ext);
  end

  assign frame_marker = (serial && !ext && state == ST_INT_SHIFT) ^ pol;

  // ****************************************************************
  // APB slave
  // ****************************************************************
  assign apb_wr    = psel && penable && pwrite;
  assign apb_setup = psel && !penable;
  assign pready    = 1'b1;

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      ctrl <= CTRL_RESET;
    end else if (apb_wr && paddr == ADDR_CTRL) begin
      ctrl <= pwdata[CTRL_W-1:0];
    end
  end

  // Read data and error settle in setup so the zero-wait access is clean
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      prdata  <= '0;
      pslverr <= 1'b0;
    end else if (apb_setup) begin
      prdata  <= '0;
      pslverr <= 1'b0;
      if (paddr == ADDR_CTRL) begin
        prdata[CTRL_W-1:0] <= ctrl;
      end else if (paddr == ADDR_STATUS) begin
        prdata[STAT_BUSY]  <= rd_busy;
        prdata[STAT_HELD]  <= held_valid;
        prdata[STAT_CHAIN] <= chain_s;
        pslverr            <= pwrite;
      end else if (paddr == ADDR_RESULT) begin
        prdata[RES_W-1:0] <= held_c;
        pslverr           <= pwrite;
      end else begin
        pslverr <= 1'b1;
      end
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!arst_n);

  property p_par_pins;
    !serial |-> pin_d7_oe && pin_d9_oe && pin_d7_out == held_c[PAR_CHAIN]
                && pin_d8_out == held_c[PAR_DOUT] && pin_d9_out == held_c[PAR_SCLK];
  endproperty
  a_par_pins: assert property (p_par_pins) else $error("parallel pins wrong");

  property p_pin_dir;
    serial |-> !pin_d7_oe && (pin_d9_oe == !ext);
  endproperty
  a_pin_dir: assert property (p_pin_dir) else $error("serial pin direction wrong");

  property p_load_code;
    ext_load |=> shreg == arp_coded($past(conv_result), $past(fmt));
  endproperty
  a_load_code: assert property (p_load_code) else $error("loaded code wrong");

  property p_ext_shift;
    serial && ext && state == ST_EXT_SHIFT && ext_upd && !conv_done |=>
      shreg[RES_MSB] == $past(shreg[RES_MSB-1]) && shreg[0] == $past(chain_bit);
  endproperty
  a_ext_shift: assert property (p_ext_shift) else $error("external shift wrong");

  property p_ext_edge;
    serial && ext && $past(state) == ST_EXT_SHIFT && !$past(conv_done)
      && shreg != $past(shreg) |-> $past(inv ? ext_fall : ext_rise);
  endproperty
  a_ext_edge: assert property (p_ext_edge) else $error("update on wrong edge");

  property p_int_stable;
    state == ST_INT_SHIFT && $past(state) == ST_INT_SHIFT
      && $changed(shreg[RES_MSB]) |-> phase == PH_DATA && !sclk_int;
  endproperty
  a_int_stable: assert property (p_int_stable) else $error("data moved mid bit");

  property p_int_len;
    $rose(state == ST_INT_SHIFT) && serial && !ext ##1 (serial && !ext)[*8]
      |-> ##[247:249] state == ST_IDLE;
  endproperty
  a_int_len: assert property (p_int_len) else $error("read length wrong");

  property p_frame;
    serial && !ext |-> frame_marker == ((state == ST_INT_SHIFT) ^ pol);
  endproperty
  a_frame: assert property (p_frame) else $error("frame marker wrong");

  property p_rdc_low;
    serial && !ext && state == ST_IDLE && !chain_s && conv_start && !conv_done
      |=> state == ST_IDLE;
  endproperty
  a_rdc_low: assert property (p_rdc_low) else $error("read started early");
endmodule
`default_nettype wire

/* bench/arp_host_model.sv */
// Host model: external serial clock, chain or read-mode level, bit capture
`timescale 1ns/1ps
`default_nettype none
module arp_host_model (
  input  wire logic sdata,
  input  wire logic sclk_dev,
  input  wire logic frame,
  output logic      sclk_ext,
  output logic      chain
);
  logic [31:0] cap;
  logic [15:0] fcap;
  logic        listen;
  logic        last_bit;
  logic        hold_bad;
  int          n_rise;

  initial begin
    sclk_ext = 1'b0;
    chain = 1'b0;
    listen = 1'b0;
  end

  task automatic arm();
    cap = '0;
    fcap = '0;
    n_rise = 0;
    hold_bad = 1'b0;
    listen = 1'b1;
  endtask

  // Clock rests at the update level so each frame opens with a sampling edge
  task automatic ext_frame(input logic inv, input int nbits, input logic [31:0] cbits);
    cap = '0;
    for (int k = 0; k < nbits; k++) begin
      chain = cbits[31-k];
      #24 sclk_ext = inv;
      #24 cap = {cap[30:0], sdata};
      sclk_ext = ~inv;
    end
    #24 chain = ~chain;
  endtask

  always @(posedge sclk_dev) begin
    if (listen) begin
      cap = {cap[30:0], sdata};
      fcap = {fcap[14:0], frame};
      last_bit = sdata;
      n_rise++;
    end
  end

  always @(negedge sclk_dev) begin
    if (listen && sdata !== last_bit) begin
      hold_bad = 1'b1;
    end
  end
endmodule
`default_nettype wire

/* bench/test_adc_result_output_port.sv */
// Self-checking bench of the result output port
`timescale 1ns/1ps
`default_nettype none
module test_adc_result_output_port;
  import arp_pkg::*;
  logic        mclk, arst_n, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, r;
  logic [15:0] conv_result, v, c;
  logic        conv_done, conv_start, e, fmt, pol;
  logic        d7_out, d7_oe, d8_out, d8_oe, d9_out, d9_oe, frame_marker, h_clk, h_chain;
  logic [31:0] cb;
  int          n_fail, checks;
  wire logic   d7_w = d7_oe ? d7_out : h_chain;
  wire logic   d9_w = d9_oe ? d9_out : h_clk;

  arp_port i_dut (.mclk(mclk), .arst_n(arst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .conv_result(conv_result), .conv_done(conv_done),
    .conv_start(conv_start), .pin_d7_in(d7_w), .pin_d7_out(d7_out), .pin_d7_oe(d7_oe),
    .pin_d8_out(d8_out), .pin_d8_oe(d8_oe), .pin_d9_in(d9_w), .pin_d9_out(d9_out),
    .pin_d9_oe(d9_oe), .frame_marker(frame_marker));
  arp_host_model i_host (.sdata(d8_out), .sclk_dev(d9_out), .frame(frame_marker),
    .sclk_ext(h_clk), .chain(h_chain));

  function automatic logic [15:0] exp_code(input logic [15:0] raw, input logic f);
    return {raw[15] ^ ~f, raw[14:0]};
  endfunction

  task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] g);
    checks++;
    if (g !== ex) begin
      n_fail++;
      $display("unexpected %s expected %h seen %h", nm, ex, g);
    end
  endtask

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge mclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) n_fail++;
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic pulse_done(input logic [15:0] val);
    @(posedge mclk);
    conv_result <= val;
    conv_done <= 1'b1;
    @(posedge mclk);
    conv_done <= 1'b0;
  endtask

  task automatic pulse_start();
    @(posedge mclk);
    conv_start <= 1'b1;
    @(posedge mclk);
    conv_start <= 1'b0;
  endtask

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  initial mclk = 1'b0;
  always #2.5 mclk = ~mclk;

  initial begin
    #100000;
    n_fail++;
    print_verdict();
  end

  initial begin
    {arst_n, psel, penable, pwrite, conv_done, conv_start} = '0;
    paddr = '0;
    pwdata = '0;
    conv_result = '0;
    n_fail = 0;
    checks = 0;
    void'($urandom(10));
    repeat (2) @(posedge mclk);
    arst_n <= 1'b1;
    // ****************************************************************
    // Registers
    // ****************************************************************
    apb(1'b0, ADDR_CTRL, '0);
    chk("ctrl reset", 32'h0000_0008, r);
    apb(1'b0, 12'h00C, '0);
    chk("unmapped error", 32'h1, 32'(e));
    apb(1'b1, ADDR_STATUS, 32'hFFFF_FFFF);
    chk("status write error", 32'h1, 32'(e));
    $display("test registers done");
    // ****************************************************************
    // Parallel port, including the two codes either side of mid-scale
    // ****************************************************************
    for (int i = 0; i < 6; i++) begin
      v = (i == 0) ? 16'h8000 : (i == 1) ? 16'h7FFF : 16'($urandom);
      fmt = i[0];
      apb(1'b1, ADDR_CTRL, {27'h0, 1'b0, fmt, 3'h0});
      pulse_done(v);
      repeat (3) @(posedge mclk);
      c = exp_code(v, fmt);
      chk("parallel bits", 32'(c[9:7]), 32'({d9_out, d8_out, d7_out}));
      chk("parallel enables", 32'h7, 32'({d9_oe, d8_oe, d7_oe}));
      apb(1'b0, ADDR_RESULT, '0);
      chk("result coding", 32'(c), r);
    end
    $display("test parallel done");
    // ****************************************************************
    // External clock, both update edges, chained bits after the word
    // ****************************************************************
    for (int inv = 0; inv < 2; inv++) begin
      v = 16'($urandom);
      fmt = ~inv[0];
      cb = $urandom;
      i_host.sclk_ext = ~inv[0];
      apb(1'b1, ADDR_CTRL, {27'h0, 1'b0, fmt, inv[0], 2'h3});
      repeat (8) @(posedge mclk);
      chk("clock pin enable", 32'h0, 32'(d9_oe));
      pulse_done(v);
      repeat (4) @(posedge mclk);
      i_host.ext_frame(inv[0], 20, cb);
      chk("external bits", {12'h0, exp_code(v, fmt), cb[31:28]}, i_host.cap);
    end
    $display("test external clock done");
    // ****************************************************************
    // Internal clock, read after and during conversion
    // ****************************************************************
    for (int rm = 0; rm < 2; rm++) begin
      v = 16'($urandom);
      fmt = 1'($urandom);
      pol = 1'($urandom);
      apb(1'b1, ADDR_CTRL, {27'h0, pol, fmt, 3'h1});
      i_host.chain = rm[0];
      repeat (6) @(posedge mclk);
      i_host.arm();
      if (rm == 0) begin
        pulse_start();
        repeat (2) @(posedge mclk);
        chk("no start before done", 32'(pol), 32'(frame_marker));
      end
      pulse_done(v);
      if (rm == 1) begin
        repeat (4) @(posedge mclk);
        chk("no start on done", 32'(pol), 32'(frame_marker));
        apb(1'b0, ADDR_STATUS, '0);
        chk("status before start", 32'h6, r);
        pulse_start();
      end
      repeat (300) @(posedge mclk);
      i_host.listen = 1'b0;
      chk("internal bit count", 32'd16, 32'(i_host.n_rise));
      chk("internal bits", 32'(exp_code(v, fmt)), {16'h0, i_host.cap[15:0]});
      chk("bit held over period", 32'h0, 32'(i_host.hold_bad));
      chk("frame active", {16'h0, {16{~pol}}}, 32'(i_host.fcap));
      chk("frame idle", 32'(pol), 32'(frame_marker));
      chk("clock driven", 32'h1, 32'(d9_oe));
      apb(1'b0, ADDR_STATUS, '0);
      chk("status after read", {29'h0, rm[0], ~rm[0], 1'b0}, r);
    end
    $display("test internal clock done");
    print_verdict();
  end
endmodule
`default_nettype wire
